// ==== hw/dbdc_pkg.sv ====
package dbdc_pkg;

  // ****************************************************************
  // register byte offsets on the apb bus
  // ****************************************************************
  localparam logic [7:0] REFRESH_OFS = 8'h44;   // refresh interval register
  localparam logic [7:0] TIMING_OFS = 8'h48;    // strobe timing register
  localparam logic [7:0] ORIGIN0_OFS = 8'h4c;   // bank 0 origin
  localparam logic [7:0] MASK0_OFS = 8'h50;     // bank 0 match mask
  localparam logic [7:0] CTRL0_OFS = 8'h54;     // bank 0 control
  localparam logic [7:0] ORIGIN1_OFS = 8'h58;   // bank 1 origin
  localparam logic [7:0] MASK1_OFS = 8'h5c;     // bank 1 match mask
  localparam logic [7:0] CTRL1_OFS = 8'h60;     // bank 1 control
  localparam logic [7:0] GSEL_OFS = 8'h68;      // global select mask

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ORIGIN_LSB = 17;         // origin bits 31..17
  localparam int TIM_HYPER_BIT = 14;      // hyper page dram enable
  localparam int TIM_CASNEG_BIT = 1;      // cas negate time select
  localparam int TIM_CASLEAD_BIT = 0;     // refresh cas lead select
  localparam int TYPE_MASK_LSB = 1;       // transfer-type mask bits 4..1
  localparam int RC_WIDTH = 12;           // refresh count width

  // ****************************************************************
  // reset values and timing counts
  // ****************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] TIMING_RESET = 16'h0000;
  localparam logic [11:0] RC_RESET = 12'h000;
  localparam int REFRESH_UNIT_CLKS = 16;      // clocks per refresh count step
  localparam int REFRESH_ZERO_CLKS = 65536;   // period for a zero count

  // page mode and lane encodings
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_BURST = 2'h1;
  localparam logic [1:0] PM_FAST = 2'h3;
  localparam logic [1:0] PS_32 = 2'h0;
  localparam logic [1:0] PS_8 = 2'h1;

  // transfer kinds, one per type mask bit (ud=1, uc=2, sd=3, sc=4)
  typedef enum logic [1:0] {
    DBDC_UD = 2'h0,
    DBDC_UC = 2'h1,
    DBDC_SD = 2'h2,
    DBDC_SC = 2'h3
  } dbdc_ttype_type;

  // bank control fields
  typedef struct packed {
    logic [1:0] lane_width;
    logic [1:0] bank_page_length;
    logic [1:0] page_mode_select;
    logic wr_en;
    logic rd_en;
  } dbdc_ctrl_type;

  // transfer request from core or external master
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic external;
    dbdc_ttype_type ttype;
  } dbdc_xfer_type;

  // per-bank decode result
  typedef struct packed {
    logic hit;
    logic strobe_en;
    logic [3:0] lane_en;
    logic [11:0] page_bytes;  // page length in bytes, wide enough for 2 KB
    logic [1:0] xfer_kind;
  } dbdc_bank_res_type;

endpackage : dbdc_pkg

// ==== hw/dbdc_bank_decode.sv ====
`timescale 1ns/10ps
// one bank's address, direction and transfer-type decode
module dbdc_bank_decode (
  input dbdc_pkg::dbdc_xfer_type xfer,
  input logic [3:0] ext_addr_pins,
  input logic [31:17] origin,
  input logic [31:0] match_mask,
  input dbdc_pkg::dbdc_ctrl_type ctrl,
  input logic global_sel_active,
  output dbdc_pkg::dbdc_bank_res_type res
);

  // ****************************************************************
  // decode
  // ****************************************************************
  logic [31:0] eff_addr;
  logic addr_ok;
  logic dir_ok;
  logic type_ok;

  // external masters see only their pins; the rest reads as zero
  always_comb begin
    eff_addr = xfer.addr;
    if (xfer.external) begin
      eff_addr[31:28] = 4'h0;
      eff_addr[27:24] = xfer.addr[27:24] & ext_addr_pins;
    end
  end

  // masked bits are dont-care in the compare
  assign addr_ok = ((eff_addr[31:17] ^ origin) & ~match_mask[31:17]) == 15'h0000;
  assign dir_ok = xfer.write ? ctrl.wr_en : ctrl.rd_en;
  // type masks only gate core transfers
  assign type_ok = xfer.external |
    ~match_mask[dbdc_pkg::TYPE_MASK_LSB + int'(xfer.ttype)];

  always_comb begin
    res.hit = xfer.valid & addr_ok & dir_ok & type_ok;
    res.strobe_en = res.hit & ~global_sel_active;
    // lane select: 32-bit, 8-bit upper lane, else 16-bit upper half
    case (ctrl.lane_width)
      dbdc_pkg::PS_32: res.lane_en = 4'hf;
      dbdc_pkg::PS_8: res.lane_en = 4'h8;
      default: res.lane_en = 4'hc;
    endcase
    case (ctrl.bank_page_length)
      2'h0: res.page_bytes = 12'h200;
      2'h1: res.page_bytes = 12'h400;
      2'h2: res.page_bytes = 12'h800;
      default: res.page_bytes = 12'h200;  // reserved code, smallest page
    endcase
    // reserved page mode falls back to normal transfers
    case (ctrl.page_mode_select)
      dbdc_pkg::PM_BURST: res.xfer_kind = dbdc_pkg::PM_BURST;
      dbdc_pkg::PM_FAST: res.xfer_kind = dbdc_pkg::PM_FAST;
      default: res.xfer_kind = dbdc_pkg::PM_NORMAL;
    endcase
  end

endmodule : dbdc_bank_decode

// ==== hw/dbdc_top.sv ====
`timescale 1ns/10ps
// Function
// - page cas negate half-clocks by precharge and hyper
// - refresh cas leads ras one or two clocks
// - refresh lead ignored by data transfers
// - origin and mask survive every reset
// - compare origin with address bits 31..17
// - external upper address bits read as zero
// - set mask bit drops address bit compare
// - core transfer type masks block bank
// - external transfers ignore transfer type masks
// - lane width codes select data lanes
// - page length codes 512, 1k, 2k
// - page mode codes normal, burst, fast
// - writes need bank write enable
// - reads need bank read enable
// - resets clear bank control registers
// - refresh register write forces immediate refresh
// - no strobes while global select active
// - refresh interval count times sixteen clocks
module dbdc_top (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input dbdc_pkg::dbdc_xfer_type xfer,
  input logic [3:0] ext_addr_pins,
  output dbdc_pkg::dbdc_bank_res_type bank0_res,
  output dbdc_pkg::dbdc_bank_res_type bank1_res,
  output logic [2:0] cas_negate_half_clks,
  output logic [1:0] refresh_cas_lead_clks,
  output logic refresh_req,
  output logic refresh_busy
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [2:0] {
    DBDC_RF_IDLE = 3'h1,
    DBDC_RF_LEAD = 3'h2,
    DBDC_RF_RAS = 3'h4
  } dbdc_rf_state_type;

  // bank origin and mask live outside the reset struct so no reset touches them
  typedef struct packed {
    logic [15:0] timing;
    logic [11:0] refresh_count;
    logic [16:0] refresh_timer;
    logic [1:0] lead_cnt;
    dbdc_rf_state_type rf_state;
    dbdc_pkg::dbdc_ctrl_type ctrl0;
    dbdc_pkg::dbdc_ctrl_type ctrl1;
    logic global_sel_active;
    logic refresh_req;
    logic [31:0] prdata;
  } dbdc_state_type;

  dbdc_state_type state_q;
  dbdc_state_type state_d;
  logic [31:17] origin_q [2];   // no reset
  logic [31:0] mask_q [2];      // no reset
  logic wr_access;
  logic rd_access;
  logic [7:0] ofs;
  logic [16:0] period;

  // one-cycle apb access phase; registers answer with no wait states
  assign pready = 1'b1;
  assign wr_access = psel & penable & pwrite;
  assign rd_access = psel & ~penable & ~pwrite;
  assign ofs = paddr[7:0];

  // unmapped offset lookup, shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      dbdc_pkg::REFRESH_OFS, dbdc_pkg::TIMING_OFS, dbdc_pkg::ORIGIN0_OFS,
      dbdc_pkg::MASK0_OFS, dbdc_pkg::CTRL0_OFS, dbdc_pkg::ORIGIN1_OFS,
      dbdc_pkg::MASK1_OFS, dbdc_pkg::CTRL1_OFS, dbdc_pkg::GSEL_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  assign pslverr = psel & penable & (~mapped(ofs) | (paddr[31:8] != 24'h000000));

  // ****************************************************************
  // refresh period
  // ****************************************************************
  // a zero count means the longest period
  always_comb begin
    if (state_q.refresh_count == dbdc_pkg::RC_RESET) begin
      period = 17'(dbdc_pkg::REFRESH_ZERO_CLKS);
    end else begin
      period = 17'({state_q.refresh_count, 4'h0});
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    state_d.refresh_req = 1'b0;
    // read data is captured in setup and held through the access phase
    if (rd_access) begin
      case (ofs)
        dbdc_pkg::REFRESH_OFS: state_d.prdata = {20'h00000, state_q.refresh_count};
        dbdc_pkg::TIMING_OFS: state_d.prdata = {16'h0000, state_q.timing};
        dbdc_pkg::ORIGIN0_OFS: state_d.prdata = {origin_q[0], 17'h00000};
        dbdc_pkg::MASK0_OFS: state_d.prdata = {mask_q[0][31:17], 12'h000, mask_q[0][4:1], 1'b0};
        dbdc_pkg::CTRL0_OFS: state_d.prdata = {24'h000000, state_q.ctrl0};
        dbdc_pkg::ORIGIN1_OFS: state_d.prdata = {origin_q[1], 17'h00000};
        dbdc_pkg::MASK1_OFS: state_d.prdata = {mask_q[1][31:17], 12'h000, mask_q[1][4:1], 1'b0};
        dbdc_pkg::CTRL1_OFS: state_d.prdata = {24'h000000, state_q.ctrl1};
        dbdc_pkg::GSEL_OFS: state_d.prdata = {31'h00000000, ~state_q.global_sel_active};
        default: state_d.prdata = 32'h00000000;
      endcase
    end
    // refresh timer counts down; expiry raises a request
    if (state_q.refresh_timer <= 17'h00001) begin
      state_d.refresh_timer = period;
      state_d.refresh_req = 1'b1;
    end else begin
      state_d.refresh_timer = state_q.refresh_timer - 17'h00001;
    end
    // register writes
    if (wr_access) begin
      case (ofs)
        dbdc_pkg::REFRESH_OFS: begin
          state_d.refresh_count = pwdata[11:0];
          // restart at the new interval and refresh at once
          state_d.refresh_timer = (pwdata[11:0] == 12'h000) ?
            17'(dbdc_pkg::REFRESH_ZERO_CLKS) : 17'({pwdata[11:0], 4'h0});
          state_d.refresh_req = 1'b1;
        end
        dbdc_pkg::TIMING_OFS: state_d.timing = pwdata[15:0];
        dbdc_pkg::CTRL0_OFS: state_d.ctrl0 = pwdata[7:0];
        dbdc_pkg::CTRL1_OFS: state_d.ctrl1 = pwdata[7:0];
        dbdc_pkg::GSEL_OFS: state_d.global_sel_active = 1'b0;
        default: ;
      endcase
    end
    // cas-before-ras refresh sequence: lead phase holds cas ahead of ras
    case (state_q.rf_state)
      DBDC_RF_IDLE: begin
        if (state_q.refresh_req) begin
          state_d.rf_state = DBDC_RF_LEAD;
          state_d.lead_cnt = refresh_cas_lead_clks;
        end
      end
      DBDC_RF_LEAD: begin
        if (state_q.lead_cnt <= 2'h1) begin
          state_d.rf_state = DBDC_RF_RAS;
        end else begin
          state_d.lead_cnt = state_q.lead_cnt - 2'h1;
        end
      end
      DBDC_RF_RAS: state_d.rf_state = DBDC_RF_IDLE;
      default: state_d.rf_state = DBDC_RF_IDLE;
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // control state; bank controls and timing clear on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q.timing <= dbdc_pkg::TIMING_RESET;
      state_q.refresh_count <= dbdc_pkg::RC_RESET;
      state_q.refresh_timer <= 17'h10000;
      state_q.lead_cnt <= 2'h0;
      state_q.rf_state <= DBDC_RF_IDLE;
      state_q.ctrl0 <= dbdc_pkg::CTRL_RESET;
      state_q.ctrl1 <= dbdc_pkg::CTRL_RESET;
      state_q.global_sel_active <= 1'b1;
      state_q.refresh_req <= 1'b0;
      state_q.prdata <= 32'h00000000;
    end else begin
      state_q <= state_d;
    end
  end

  // origin and mask take writes only, never reset
  always_ff @(posedge pclk) begin
    if (wr_access && ofs == dbdc_pkg::ORIGIN0_OFS) origin_q[0] <= pwdata[31:17];
    if (wr_access && ofs == dbdc_pkg::ORIGIN1_OFS) origin_q[1] <= pwdata[31:17];
    if (wr_access && ofs == dbdc_pkg::MASK0_OFS) mask_q[0] <= pwdata;
    if (wr_access && ofs == dbdc_pkg::MASK1_OFS) mask_q[1] <= pwdata;
  end

  // ****************************************************************
  // timing selections
  // ****************************************************************
  // cas negate in half clocks: standard 1 or 3, hyper page 2 or 4
  always_comb begin
    case ({state_q.timing[dbdc_pkg::TIM_HYPER_BIT], state_q.timing[dbdc_pkg::TIM_CASNEG_BIT]})
      2'h0: cas_negate_half_clks = 3'h1;
      2'h1: cas_negate_half_clks = 3'h3;
      2'h2: cas_negate_half_clks = 3'h2;
      default: cas_negate_half_clks = 3'h4;  // two full clocks with hyper page
    endcase
  end

  // lead select feeds only the refresh sequence, never data timing
  assign refresh_cas_lead_clks = state_q.timing[dbdc_pkg::TIM_CASLEAD_BIT] ? 2'h2 : 2'h1;
  assign refresh_req = state_q.refresh_req;
  assign refresh_busy = state_q.rf_state != DBDC_RF_IDLE;
  assign prdata = state_q.prdata;

  // ****************************************************************
  // bank decoders
  // ****************************************************************
  dbdc_bank_decode u_bank0 (
    .xfer(xfer),
    .ext_addr_pins(ext_addr_pins),
    .origin(origin_q[0]),
    .match_mask(mask_q[0]),
    .ctrl(state_q.ctrl0),
    .global_sel_active(state_q.global_sel_active),
    .res(bank0_res)
  );

  dbdc_bank_decode u_bank1 (
    .xfer(xfer),
    .ext_addr_pins(ext_addr_pins),
    .origin(origin_q[1]),
    .match_mask(mask_q[1]),
    .ctrl(state_q.ctrl1),
    .global_sel_active(state_q.global_sel_active),
    .res(bank1_res)
  );

endmodule : dbdc_top

// ==== test/dbdc_top_props.sv ====
`timescale 1ns/10ps
// ****************************************************************
// port checker for the bank decode and config block
// ****************************************************************
module dbdc_top_chk (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input dbdc_pkg::dbdc_xfer_type xfer,
  input logic [3:0] ext_addr_pins,
  input dbdc_pkg::dbdc_bank_res_type bank0_res,
  input dbdc_pkg::dbdc_bank_res_type bank1_res,
  input logic [2:0] cas_negate_half_clks,
  input logic [1:0] refresh_cas_lead_clks,
  input logic refresh_req,
  input logic refresh_busy
);
  logic [15:0] tim_q; // shadow of the strobe timing register
  logic gsel_off_q; // shadow: global select has been disabled
  logic acc_wr; // apb write taken at this edge
  assign acc_wr = psel && penable && pwrite && pready;
  // shadows track apb writes so comb outputs can be judged against them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tim_q <= dbdc_pkg::TIMING_RESET;
      gsel_off_q <= 1'b0;
    end else if (acc_wr) begin
      if (paddr == {24'h0, dbdc_pkg::TIMING_OFS}) tim_q <= pwdata[15:0];
      if (paddr == {24'h0, dbdc_pkg::GSEL_OFS}) gsel_off_q <= 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ref_wr;
    acc_wr && paddr == {24'h0, dbdc_pkg::REFRESH_OFS};
  endsequence
  sequence s_ref_go;
    refresh_req ##1 (!refresh_req && refresh_busy);
  endsequence
  a_refresh_on_write: assert property (s_ref_wr |=> s_ref_go)
    else $error("no refresh after refresh register write");
  a_busy_after_req: assert property ($rose(refresh_busy) |-> $past(refresh_req))
    else $error("refresh busy without a request");
  a_cas_negate_time: assert property (cas_negate_half_clks == (tim_q[14] ?
    (tim_q[1] ? 3'h4 : 3'h2) : (tim_q[1] ? 3'h3 : 3'h1))) else $error("cas negate time wrong");
  a_refresh_lead_time: assert property (refresh_cas_lead_clks == (tim_q[0] ? 2'h2 : 2'h1))
    else $error("refresh cas lead wrong");
  a_lead_not_data: assert property ($changed(tim_q[0]) && $stable(tim_q[1])
    && $stable(tim_q[14]) |-> $stable(cas_negate_half_clks)) else $error("lead moved page timing");
  a_no_strobe_gsel: assert property (!gsel_off_q |->
    !bank0_res.strobe_en && !bank1_res.strobe_en) else $error("strobe while global select active");
  a_strobe_on_hit: assert property (gsel_off_q |-> bank0_res.strobe_en == bank0_res.hit)
    else $error("strobe does not follow hit");
  a_idle_no_hit: assert property (!xfer.valid |-> !bank0_res.hit && !bank1_res.hit)
    else $error("hit without a transfer");
  a_kind_not_reserved: assert property (bank0_res.xfer_kind != 2'h2)
    else $error("reserved transfer kind produced");
endmodule : dbdc_top_chk
bind dbdc_top dbdc_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .xfer(xfer), .ext_addr_pins(ext_addr_pins),
  .bank0_res(bank0_res), .bank1_res(bank1_res), .cas_negate_half_clks(cas_negate_half_clks),
  .refresh_cas_lead_clks(refresh_cas_lead_clks), .refresh_req(refresh_req),
  .refresh_busy(refresh_busy));

// ==== test/dbdc_dram_model.sv ====
`timescale 1ns/10ps
// ****************************************************************
// dram bank pair, seen only through refresh requests
// ****************************************************************
module dbdc_dram_model (
  input logic pclk,
  input logic presetn,
  input logic refresh_req,
  output int ref_gap
);
  int since; // cycles since the last refresh request
  // a bank only needs the spacing of refreshes, so that is all it keeps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since <= 0;
      ref_gap <= 0;
    end else begin
      since <= refresh_req ? 1 : since + 1;
      if (refresh_req) ref_gap <= since;
    end
  end
endmodule : dbdc_dram_model

// ==== test/dram_bank_decode_and_config_tb.sv ====
`timescale 1ns/10ps
module dram_bank_decode_and_config_tb;
  // ****************************************************************
  // signals, design and far-side model
  // ****************************************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic refresh_req, refresh_busy;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] ext_addr_pins;
  logic [2:0] cas_neg;
  logic [1:0] cas_lead;
  dbdc_pkg::dbdc_xfer_type xfer;
  dbdc_pkg::dbdc_bank_res_type res0, res1;
  int errors, checks_done, cycles, ref_gap;
  localparam logic [31:0] A0 = 32'h0010_0000; // bank 0 start
  dbdc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xfer(xfer), .ext_addr_pins(ext_addr_pins), .bank0_res(res0),
    .bank1_res(res1), .cas_negate_half_clks(cas_neg), .refresh_cas_lead_clks(cas_lead),
    .refresh_req(refresh_req), .refresh_busy(refresh_busy));
  dbdc_dram_model u_dram (.pclk(pclk), .presetn(presetn), .refresh_req(refresh_req),
    .ref_gap(ref_gap));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // hang guard: the whole run needs well under two thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 5000) begin
      errors++;
      end_sim();
    end
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; holds everything until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // present a transfer and settle before judging the decode
  task automatic drv(input logic [31:0] a, input logic w, input logic e, input logic [1:0] t);
    @(posedge pclk);
    xfer <= '{1'b1, a, w, e, dbdc_pkg::dbdc_ttype_type'(t)};
    @(negedge pclk);
  endtask : drv
  task automatic wreq;
    for (int i = 0; i < 100 && refresh_req !== 1'b1; i++) @(negedge pclk);
    @(negedge pclk);
  endtask : wreq
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    apb(1, dbdc_pkg::ORIGIN0_OFS, 32'h1234_0000);
    apb(1, dbdc_pkg::MASK0_OFS, 32'h0006_001e);
    apb(1, dbdc_pkg::CTRL0_OFS, 32'h0000_00a5);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1, dbdc_pkg::TIMING_OFS, 32'h0);
    apb(0, dbdc_pkg::CTRL0_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(0, dbdc_pkg::ORIGIN0_OFS, 32'h0);
    chk(rd, 32'h1234_0000);
    apb(0, dbdc_pkg::MASK0_OFS, 32'h0);
    chk(rd, 32'h0006_001e);
    apb(0, 8'h64, 32'h0);
    chk(err, 1'b1);
  endtask : t_reset
  task automatic t_decode;
    apb(1, dbdc_pkg::ORIGIN0_OFS, A0);
    apb(1, dbdc_pkg::MASK0_OFS, 32'h000e_0000);
    apb(1, dbdc_pkg::CTRL0_OFS, 32'h0000_000f);
    drv(A0, 0, 0, 0);
    chk(res0.strobe_en, 1'b0);
    apb(1, dbdc_pkg::GSEL_OFS, 32'h0);
    @(negedge pclk);
    chk(res0.strobe_en, 1'b1);
    drv(32'h001e_fffc, 0, 0, 0);
    chk(res0.hit, 1'b1);
    drv(32'h0020_0000, 0, 0, 0);
    chk(res0.hit, 1'b0);
    drv(32'h8010_0000, 0, 0, 0);
    chk(res0.hit, 1'b0);
  endtask : t_decode
  task automatic t_dir;
    for (int i = 1; i < 3; i++) begin
      apb(1, dbdc_pkg::CTRL0_OFS, 32'h0c | 32'(i));
      drv(A0, 1, 0, 0);
      chk(res0.hit, i[1]);
      drv(A0, 0, 0, 0);
      chk(res0.hit, i[0]);
    end
    apb(1, dbdc_pkg::CTRL0_OFS, 32'h0f);
  endtask : t_dir
  task automatic t_type;
    for (int t = 0; t < 4; t++) begin
      apb(1, dbdc_pkg::MASK0_OFS, 32'h000e_0000 | (32'h2 << t));
      for (int u = 0; u < 4; u++) begin
        drv(A0, 0, 0, u[1:0]);
        chk(res0.hit, u != t);
        drv(A0, 0, 1, u[1:0]);
        chk(res0.hit, 1'b1);
      end
    end
  endtask : t_type
  task automatic t_ext;
    apb(1, dbdc_pkg::CTRL1_OFS, 32'h03);
    drv(32'h0500_0000, 0, 1, 0);
    chk(res1.hit, 1'b0);
    @(posedge pclk);
    ext_addr_pins <= 4'h5;
    drv(32'hf500_0000, 0, 1, 0);
    chk(res1.hit, 1'b1);
    drv(32'hf500_0000, 0, 0, 0);
    chk(res1.hit, 1'b0);
    @(posedge pclk);
    ext_addr_pins <= 4'h0;
    apb(1, dbdc_pkg::MASK1_OFS, 32'h0f00_0000);
    drv(32'h0500_0000, 0, 1, 0);
    chk(res1.hit, 1'b1);
  endtask : t_ext
  task automatic t_fields;
    for (int c = 0; c < 4; c++) begin
      apb(1, dbdc_pkg::CTRL0_OFS, {24'h0, c[1:0], c[1:0], c[1:0], 2'b11});
      drv(A0, 0, 0, 0);
      chk(res0.lane_en, c == 0 ? 4'hf : c == 1 ? 4'h8 : 4'hc);
      chk(res0.page_bytes, c == 1 ? 12'h400 : c == 2 ? 12'h800 : 12'h200);
      chk(res0.xfer_kind, c == 1 ? 2'h1 : c == 3 ? 2'h3 : 2'h0);
    end
  endtask : t_fields
  task automatic t_timing;
    for (int v = 0; v < 8; v++) begin
      apb(1, dbdc_pkg::TIMING_OFS, {17'h0, v[2], 12'h0, v[1], v[0]});
      drv(A0, 0, 0, 0);
      chk(cas_neg, v[2] ? (v[1] ? 3'h4 : 3'h2) : (v[1] ? 3'h3 : 3'h1));
      chk(cas_lead, v[0] ? 2'h2 : 2'h1);
      chk(res0.xfer_kind, 2'h3);
    end
  endtask : t_timing
  task automatic t_refresh;
    apb(1, dbdc_pkg::REFRESH_OFS, 32'h1);
    @(negedge pclk);
    chk(refresh_req, 1'b1);
    @(negedge pclk);
    chk(refresh_busy, 1'b1);
    repeat (2) wreq();
    chk(ref_gap, 32'd16);
    apb(1, dbdc_pkg::REFRESH_OFS, 32'h2);
    repeat (2) wreq();
    chk(ref_gap, 32'd32);
  endtask : t_refresh
  task automatic end_sim;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // main sequence: reset two cycles, then every scenario in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    xfer = '0;
    ext_addr_pins = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1, dbdc_pkg::TIMING_OFS, 32'h0);
    apb(1, dbdc_pkg::ORIGIN1_OFS, 32'h0500_0000);
    apb(1, dbdc_pkg::MASK1_OFS, 32'h0);
    t_reset();
    t_decode();
    t_dir();
    t_type();
    t_ext();
    t_fields();
    t_timing();
    t_refresh();
    end_sim();
  end
endmodule : dram_bank_decode_and_config_tb
